// >>> rtl/swc_regs.svh
`ifndef SWC_REGS_SVH
`define SWC_REGS_SVH
// --------------------
// register offsets (byte addresses)
// --------------------
`define SWC_ADDR_CTRL 8'h00
`define SWC_ADDR_SRC_EN 8'h04
`define SWC_ADDR_STATUS 8'h08
`define SWC_ADDR_IRQ_STAT 8'h0C
`define SWC_ADDR_IRQ_CLR 8'h10
`define SWC_ADDR_IRQ_EN 8'h14
// --------------------
// control field positions
// --------------------
`define SWC_CTRL_WDT_EN 0
`define SWC_CTRL_RC_MODE 1
`define SWC_CTRL_GIE 2
`define SWC_CTRL_T1_ASYNC 3
// --------------------
// wake source enable positions, also the synchroniser lane order
// --------------------
`define SWC_SRC_EXT_INT 0
`define SWC_SRC_PORT_B 1
`define SWC_SRC_PERIPH 2
`define SWC_SRC_TIMER_ONE 3
`define SWC_LANE_WDT 4
`define SWC_LANE_MASTER_CLEAR_PIN_N 5
// --------------------
// event bits of the interrupt status register
// --------------------
`define SWC_EV_SLEEP 0
`define SWC_EV_SLEEP_NOP 1
`define SWC_EV_WAKE_WDT 2
`define SWC_EV_WAKE_INT 3
`define SWC_EV_MASTER_CLEAR_PIN 4
// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define SWC_CTRL_RESET 4'h0
`define SWC_SRC_EN_RESET 4'h0
`define SWC_IRQ_EN_RESET 5'h00
// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define SWC_CLK_NS 100
`define SWC_OSC_NS 100
`define SWC_OSC_PER_INSTR 4
`define SWC_OST_PERIODS 1024
`define SWC_OST_CYCLES ((`SWC_OST_PERIODS * `SWC_OSC_NS + `SWC_CLK_NS - 1) / `SWC_CLK_NS)
`define SWC_INT_VECTOR 13'h0004
`endif

// >>> rtl/swc_pkg.sv
package swc_pkg;
  // --------------------------------------------------------------------------
  // sequencer states, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_RESET = 5'h01, // master clear held or just released
    ST_RUN   = 5'h02, // normal execution
    ST_SLEEP = 5'h04, // oscillator off, waiting for a wake event
    ST_OST   = 5'h08, // oscillator start-up delay
    ST_WAKE  = 5'h10  // executing the prefetched instruction
  } swc_state_e;
  typedef logic [12:0] swc_addr_t;
endpackage : swc_pkg

// >>> rtl/swc_ctl_if.sv
`timescale 1ns/1ps
`default_nettype none
// links the sequencer core with the wake detector and start-up timer
interface swc_ctl_if;
  logic [3:0] src_en; // per-source wake enables
  logic t1_async; // timer one counts asynchronously
  logic wdt_en; // watchdog enabled
  logic master_clear_pin_active; // synchronised master clear held low
  logic int_pending; // an enabled interrupt flag is set
  logic wdt_wake; // enabled watchdog timed out
  logic ost_start; // start the oscillator start-up count
  logic ost_done; // start-up count finished
  modport core (output src_en, t1_async, wdt_en, ost_start,
                input master_clear_pin_active, int_pending, wdt_wake, ost_done);
  modport det (input src_en, t1_async, wdt_en,
               output master_clear_pin_active, int_pending, wdt_wake);
  modport tmr (input ost_start, output ost_done);
endinterface : swc_ctl_if
`default_nettype wire

// >>> rtl/swc_wake_detect.sv
`timescale 1ns/1ps
`default_nettype none
`include "swc_regs.svh"
// synchronises the clockless wake sources and qualifies them
module swc_wake_detect (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [5:0] raw,
  swc_ctl_if.det ctl
);
  typedef struct packed {
    logic [5:0] meta; // first synchroniser stage
    logic [5:0] sync; // second synchroniser stage
    logic master_clear_pin; // master clear level
    logic intp; // enabled interrupt pending
    logic wdt; // watchdog wake
  } swc_det_s;
  swc_det_s s_r;
  swc_det_s s_nxt;
  // --------------------------------------------------------------------------
  // qualification
  // --------------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.meta = raw;
    s_nxt.sync = s_r.meta;
    s_nxt.master_clear_pin = ~s_r.sync[`SWC_LANE_MASTER_CLEAR_PIN_N];
    // only individual enables gate the wake, timer one only when asynchronous
    s_nxt.intp = |(s_r.sync[3:0] & ctl.src_en &
                  {ctl.t1_async, 3'h7});
    s_nxt.wdt = s_r.sync[`SWC_LANE_WDT] & ctl.wdt_en;
  end
  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      // the master clear pin idles high, so no false clear follows reset
      s_r.meta[`SWC_LANE_MASTER_CLEAR_PIN_N] <= 1'b1;
      s_r.sync[`SWC_LANE_MASTER_CLEAR_PIN_N] <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign ctl.master_clear_pin_active = s_r.master_clear_pin;
  assign ctl.int_pending = s_r.intp;
  assign ctl.wdt_wake = s_r.wdt;
endmodule : swc_wake_detect
`default_nettype wire

// >>> rtl/swc_ost_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "swc_regs.svh"
// counts the oscillator start-up delay after a wake or reset
module swc_ost_timer #(
  parameter int OST_CYCLES = `SWC_OST_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  swc_ctl_if.tmr ctl
);
  initial begin
    if (OST_CYCLES < 1 || OST_CYCLES > 4096) begin
      $error("start-up count out of range");
    end
  end
  typedef struct packed {
    logic busy; // counting
    logic [12:0] cnt; // cycles left
    logic done; // one-cycle finish pulse
  } swc_ost_s;
  swc_ost_s s_r;
  swc_ost_s s_nxt;
  // --------------------------------------------------------------------------
  // countdown
  // --------------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (ctl.ost_start) begin
      s_nxt.busy = 1'b1;
      s_nxt.cnt = 13'(OST_CYCLES - 1);
    end else if (s_r.busy) begin
      if (s_r.cnt == 13'h0000) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end else begin
        s_nxt.cnt = 13'(s_r.cnt - 13'h0001);
      end
    end
  end
  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign ctl.ost_done = s_r.done;
endmodule : swc_ost_timer
`default_nettype wire

// >>> rtl/swc_sleep_ctrl.sv
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "swc_regs.svh"
// Function
// - wake on master clear, watchdog, interrupt
// - master clear resets; others continue execution
// - powerdown flag set at reset, cleared by sleep
// - watchdog wake clears timeout flag
// - only clockless sources wake while asleep
// - timer one wakes only when asynchronous
// - sleep prefetches instruction at next address
// - individual enable gates wake, not global
// - run prefetched instruction, then vector if enabled
// - pending interrupt, global off: sleep is nop
// - interrupt during sleep: complete, then wake
// - crystal modes wait 1024 periods; RC none
// - four periods per cycle; branches add nop
// - sleep clears watchdog if enabled, sets timeout, clears powerdown, stops oscillator
module swc_sleep_ctrl #(
  parameter int OST_CYCLES = `SWC_OST_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic sleep_instr,
  input wire logic watchdog_clear_instruction,
  input wire logic branch_or_skip,
  input wire logic [12:0] program_counter,
  input wire logic master_clear_pin_n,
  input wire logic watchdog_timeout,
  input wire logic ext_int_flag,
  input wire logic port_b_change_flag,
  input wire logic periph_flag,
  input wire logic timer_one_flag,
  output logic instr_cycle_en,
  output logic nop_cycle,
  output logic device_reset,
  output logic osc_driver_on,
  output logic watchdog_clear,
  output logic prefetch_valid,
  output logic [12:0] prefetch_addr,
  output logic exec_prefetched,
  output logic vector_valid,
  output logic [12:0] vector_addr,
  output logic asleep,
  output logic timeout_flag,
  output logic powerdown_flag,
  output logic irq
);
  // --------------------------------------------------------------------------
  // parameter check
  // --------------------------------------------------------------------------
  initial begin
    if (OST_CYCLES < 1 || OST_CYCLES > 4096) begin
      $error("start-up count out of range");
    end
  end

  // --------------------------------------------------------------------------
  // reset release synchroniser
  // --------------------------------------------------------------------------
  logic rst_meta_r; // first release stage
  logic rst_n_r; // released reset used everywhere else

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  swc_ctl_if ctl (); // links to detector and timer

  swc_wake_detect u_det (
    .clk(clk),
    .rst_n(rst_n_r),
    .raw({master_clear_pin_n, watchdog_timeout, timer_one_flag, periph_flag,
          port_b_change_flag, ext_int_flag}),
    .ctl(ctl.det)
  );

  swc_ost_timer #(
    .OST_CYCLES(OST_CYCLES)
  ) u_ost (
    .clk(clk),
    .rst_n(rst_n_r),
    .ctl(ctl.tmr)
  );

  // --------------------------------------------------------------------------
  // state of the block
  // --------------------------------------------------------------------------
  typedef struct packed {
    swc_pkg::swc_state_e state; // sequencer state
    logic [1:0] div; // oscillator periods within a cycle
    logic tick; // instruction cycle enable
    logic nop_next; // next cycle is a flush
    logic nop_cycle; // current cycle is a flush
    logic rst_out; // full device reset
    logic osc_on; // oscillator driver
    logic wdt_clr; // watchdog clear pulse
    logic pf_valid; // prefetch pulse
    logic [12:0] pf_addr; // prefetch address
    logic exec_pf; // prefetched instruction executes
    logic exec_done; // prefetched instruction already issued
    logic vec_valid; // branch to interrupt vector
    logic from_wake; // start-up belongs to a wake
    logic wake_by_int; // wake came from an interrupt
    logic to_flag; // timeout flag
    logic pd_flag; // powerdown flag
    logic [3:0] ctrl; // control register
    logic [3:0] src_en; // wake source enables
    logic [4:0] irq_en; // event enables
    logic [4:0] irq_stat; // sticky events
    logic irq; // interrupt output
    logic ost_start; // start the start-up count
    logic [31:0] rdata; // read data
  } swc_core_s;

  swc_core_s s_r;
  swc_core_s s_nxt;
  logic [4:0] ev; // events raised this cycle
  logic [4:0] clr; // events cleared by software this cycle
  logic crystal; // crystal or resonator oscillator mode
  logic global_int_enable; // global interrupt enable

  // --------------------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    ev = 5'h00;
    clr = 5'h00;
    crystal = ~s_r.ctrl[`SWC_CTRL_RC_MODE];
    global_int_enable = s_r.ctrl[`SWC_CTRL_GIE];
    s_nxt.tick = 1'b0;
    s_nxt.wdt_clr = 1'b0;
    s_nxt.pf_valid = 1'b0;
    s_nxt.exec_pf = 1'b0;
    s_nxt.vec_valid = 1'b0;
    s_nxt.ost_start = 1'b0;
    s_nxt.rdata = 32'h0000_0000;

    // register writes
    if (wr_en) begin
      if (addr == `SWC_ADDR_CTRL) begin
        s_nxt.ctrl = wdata[3:0];
      end else if (addr == `SWC_ADDR_SRC_EN) begin
        s_nxt.src_en = wdata[3:0];
      end else if (addr == `SWC_ADDR_IRQ_CLR) begin
        clr = wdata[4:0];
      end else if (addr == `SWC_ADDR_IRQ_EN) begin
        s_nxt.irq_en = wdata[4:0];
      end
    end

    // register reads, data valid the following cycle only
    if (rd_en) begin
      if (addr == `SWC_ADDR_CTRL) begin
        s_nxt.rdata = {28'h0000000, s_r.ctrl};
      end else if (addr == `SWC_ADDR_SRC_EN) begin
        s_nxt.rdata = {28'h0000000, s_r.src_en};
      end else if (addr == `SWC_ADDR_STATUS) begin
        s_nxt.rdata = {24'h000000, 5'(s_r.state), s_r.state == swc_pkg::ST_SLEEP,
                       s_r.pd_flag, s_r.to_flag};
      end else if (addr == `SWC_ADDR_IRQ_STAT) begin
        s_nxt.rdata = {27'h0000000, s_r.irq_stat};
      end else if (addr == `SWC_ADDR_IRQ_EN) begin
        s_nxt.rdata = {27'h0000000, s_r.irq_en};
      end else begin
        s_nxt.rdata = 32'h0000_0000; // unmapped and write-only read zero
      end
    end

    if (ctl.master_clear_pin_active) begin
      // master clear overrides the sequencer and asserts device reset; registers keep their values
      if (s_r.state == swc_pkg::ST_SLEEP) begin
        ev[`SWC_EV_MASTER_CLEAR_PIN] = 1'b1;
      end
      s_nxt.state = swc_pkg::ST_RESET;
      s_nxt.rst_out = 1'b1;
      s_nxt.osc_on = 1'b1;
      s_nxt.div = 2'h0;
      s_nxt.nop_next = 1'b0;
      s_nxt.nop_cycle = 1'b0;
      s_nxt.exec_done = 1'b0;
      s_nxt.wake_by_int = 1'b0;
    end else begin
      case (s_r.state)
        swc_pkg::ST_RESET: begin
          // release: crystal modes wait for the oscillator first
          s_nxt.rst_out = 1'b0;
          s_nxt.from_wake = 1'b0;
          if (crystal) begin
            s_nxt.ost_start = 1'b1;
            s_nxt.state = swc_pkg::ST_OST;
          end else begin
            s_nxt.state = swc_pkg::ST_RUN;
          end
        end
        swc_pkg::ST_RUN: begin
          // four oscillator periods make one instruction cycle
          s_nxt.div = 2'(s_r.div + 2'h1);
          if (s_r.div == 2'(`SWC_OSC_PER_INSTR - 1)) begin
            s_nxt.tick = 1'b1;
            s_nxt.nop_cycle = s_r.nop_next;
            s_nxt.nop_next = 1'b0;
          end
          if (s_r.tick && !s_r.nop_cycle) begin
            if (branch_or_skip) begin
              s_nxt.nop_next = 1'b1;
            end
            if (watchdog_clear_instruction) begin
              // explicit clear before sleep keeps the watchdog quiet
              s_nxt.wdt_clr = 1'b1;
              s_nxt.to_flag = 1'b1;
              s_nxt.pd_flag = 1'b1;
            end else if (sleep_instr) begin
              s_nxt.pf_valid = 1'b1;
              s_nxt.pf_addr = 13'(program_counter + 13'h0001);
              if (ctl.int_pending && !global_int_enable) begin
                // pending flag already there: sleep acts as nop
                ev[`SWC_EV_SLEEP_NOP] = 1'b1;
              end else begin
                // sleep takes effect
                s_nxt.wdt_clr = s_r.ctrl[`SWC_CTRL_WDT_EN];
                s_nxt.to_flag = 1'b1;
                s_nxt.pd_flag = 1'b0;
                s_nxt.osc_on = 1'b0;
                s_nxt.state = swc_pkg::ST_SLEEP;
                s_nxt.div = 2'h0;
                s_nxt.nop_next = 1'b0;
                s_nxt.wake_by_int = 1'b0;
                ev[`SWC_EV_SLEEP] = 1'b1;
              end
            end
          end
        end
        swc_pkg::ST_SLEEP: begin
          // no instruction cycles; detector runs off the free reference
          if (ctl.wdt_wake || ctl.int_pending) begin
            s_nxt.osc_on = 1'b1;
            s_nxt.from_wake = 1'b1;
            s_nxt.exec_done = 1'b0;
            if (ctl.wdt_wake) begin
              s_nxt.to_flag = 1'b0;
              ev[`SWC_EV_WAKE_WDT] = 1'b1;
            end else begin
              s_nxt.wake_by_int = 1'b1;
              ev[`SWC_EV_WAKE_INT] = 1'b1;
            end
            if (crystal) begin
              s_nxt.ost_start = 1'b1;
              s_nxt.state = swc_pkg::ST_OST;
            end else begin
              s_nxt.state = swc_pkg::ST_WAKE;
            end
          end
        end
        swc_pkg::ST_OST: begin
          // hold execution until the oscillator is stable
          if (ctl.ost_done) begin
            s_nxt.div = 2'h0;
            if (s_r.from_wake) begin
              s_nxt.state = swc_pkg::ST_WAKE;
            end else begin
              s_nxt.state = swc_pkg::ST_RUN;
            end
          end
        end
        swc_pkg::ST_WAKE: begin
          // first cycle runs the prefetched instruction
          s_nxt.div = 2'(s_r.div + 2'h1);
          if (s_r.div == 2'(`SWC_OSC_PER_INSTR - 1)) begin
            s_nxt.tick = 1'b1;
            if (!s_r.exec_done) begin
              s_nxt.exec_pf = 1'b1;
              s_nxt.exec_done = 1'b1;
            end else begin
              // then branch to the vector only if global enable is set
              s_nxt.vec_valid = s_r.wake_by_int && global_int_enable;
              s_nxt.nop_cycle = 1'b0;
              s_nxt.wake_by_int = 1'b0;
              s_nxt.state = swc_pkg::ST_RUN;
            end
          end
        end
        default: begin
          s_nxt.state = swc_pkg::ST_RESET;
        end
      endcase
    end

    // sticky events, a new event wins over a clear in the same cycle
    s_nxt.irq_stat = (s_r.irq_stat & ~clr) | ev;
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_en);
  end

  // --------------------------------------------------------------------------
  // state register, flags start as after power-up
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      s_r <= '0;
      s_r.state <= swc_pkg::ST_RESET;
      s_r.rst_out <= 1'b1;
      s_r.osc_on <= 1'b1;
      s_r.to_flag <= 1'b1;
      s_r.pd_flag <= 1'b1;
      s_r.ctrl <= `SWC_CTRL_RESET;
      s_r.src_en <= `SWC_SRC_EN_RESET;
      s_r.irq_en <= `SWC_IRQ_EN_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // helper controls and outputs
  // --------------------------------------------------------------------------
  assign ctl.src_en = s_r.src_en;
  assign ctl.t1_async = s_r.ctrl[`SWC_CTRL_T1_ASYNC];
  assign ctl.wdt_en = s_r.ctrl[`SWC_CTRL_WDT_EN];
  assign ctl.ost_start = s_r.ost_start;

  assign rdata = s_r.rdata;
  assign instr_cycle_en = s_r.tick;
  assign nop_cycle = s_r.nop_cycle;
  assign device_reset = s_r.rst_out;
  assign osc_driver_on = s_r.osc_on;
  assign watchdog_clear = s_r.wdt_clr;
  assign prefetch_valid = s_r.pf_valid;
  assign prefetch_addr = s_r.pf_addr;
  assign exec_prefetched = s_r.exec_pf;
  assign vector_valid = s_r.vec_valid;
  assign vector_addr = `SWC_INT_VECTOR; // constant, no logic
  assign asleep = (s_r.state == swc_pkg::ST_SLEEP);
  assign timeout_flag = s_r.to_flag;
  assign powerdown_flag = s_r.pd_flag;
  assign irq = s_r.irq;
endmodule : swc_sleep_ctrl
`default_nettype wire

// >>> testbench/swc_sleep_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------
// port checker for the sleep and wake controller
// --------------------
module swc_sleep_ctrl_asserts #(
  parameter int OST_CYCLES = 1024
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  input wire logic [12:0] program_counter,
  input wire logic master_clear_pin_n,
  input wire logic watchdog_timeout,
  input wire logic branch_or_skip,
  input wire logic instr_cycle_en,
  input wire logic nop_cycle,
  input wire logic device_reset,
  input wire logic osc_driver_on,
  input wire logic prefetch_valid,
  input wire logic [12:0] prefetch_addr,
  input wire logic exec_prefetched,
  input wire logic vector_valid,
  input wire logic [12:0] vector_addr,
  input wire logic asleep,
  input wire logic timeout_flag,
  input wire logic powerdown_flag
);
  localparam int EXW = OST_CYCLES + 12; // longest wake to first instruction
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // asleep, then a watchdog wake
  sequence wdt_wake_s; asleep ##1 (!asleep && !device_reset && watchdog_timeout); endsequence
  // three idle clocks after a cycle
  sequence gap_s; !instr_cycle_en [*3]; endsequence
  rd_idle_a: assert property (!$past(rd_en) |-> rdata == 32'h0)
    else $error("stray read data");
  instr_gap_a: assert property (instr_cycle_en |=> gap_s)
    else $error("short instruction cycle");
  flush_nop_a: assert property (instr_cycle_en && branch_or_skip && !nop_cycle |-> ##4 nop_cycle)
    else $error("no flush after branch");
  prefetch_a: assert property (prefetch_valid |-> prefetch_addr == $past(program_counter) + 13'h1)
    else $error("prefetch address wrong");
  sleep_flags_a: assert property ($rose(asleep) |-> !powerdown_flag && timeout_flag)
    else $error("flags wrong on sleep entry");
  osc_off_a: assert property (asleep |-> !osc_driver_on && !instr_cycle_en)
    else $error("clock activity while asleep");
  wdt_wake_a: assert property (wdt_wake_s |-> ##[0:2] !timeout_flag)
    else $error("timeout flag kept on watchdog wake");
  wake_exec_a: assert property ($fell(asleep) && !device_reset && master_clear_pin_n
    |-> ##[1:EXW] exec_prefetched)
    else $error("no prefetched run after wake");
  vector_a: assert property (vector_valid |-> vector_addr == 13'h0004 && $past(exec_prefetched, 4))
    else $error("vector branch wrong");
  master_clear_pin_rst_a: assert property ($fell(master_clear_pin_n) |-> ##[2:5] device_reset)
    else $error("master clear did not reset");
endmodule : swc_sleep_ctrl_asserts
bind swc_sleep_ctrl swc_sleep_ctrl_asserts #(.OST_CYCLES(OST_CYCLES)) chk_u (.*);
`default_nettype wire

// >>> testbench/swc_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------
// sequencer model: holds a request until a cycle takes it
// --------------------
module swc_seq_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic step,
  input wire logic flush,
  input wire logic [1:0] op,
  input wire logic op_v,
  output logic sleep_instr,
  output logic watchdog_clear_instruction,
  output logic branch_or_skip,
  output logic [12:0] program_counter,
  output logic busy
);
  logic [1:0] op_r; // 1 sleep, 2 watchdog clear, 3 branch
  // pc moves on when a request is taken; flush cycles take nothing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_r <= 2'h0;
      program_counter <= 13'h0010;
    end else if (op_v) begin
      op_r <= op;
    end else if (step && !flush && op_r != 2'h0) begin
      op_r <= 2'h0; // plain nops follow every request
      program_counter <= program_counter + ((op_r == 2'h3) ? 13'h0008 : 13'h0001);
    end
  end
  assign sleep_instr = (op_r == 2'h1);
  assign watchdog_clear_instruction = (op_r == 2'h2);
  assign branch_or_skip = (op_r == 2'h3);
  assign busy = (op_r != 2'h0);
endmodule : swc_seq_model
`default_nettype wire

// >>> testbench/tb_swc_sleep_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "swc_regs.svh"
module tb_swc_sleep_ctrl;
  localparam int OST = 8; // shortened start-up count
  logic clk = 1'b0, reset_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, master_clear_pin_n = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [4:0] fl = 5'h00; // wake levels: ext, port b, periph, timer one, watchdog
  logic [1:0] op = 2'h0;
  logic op_v = 1'b0, vseen = 1'b0, sleep_instr, watchdog_clear_instruction, branch_or_skip, busy;
  logic instr_cycle_en, nop_cycle, device_reset, osc_driver_on, watchdog_clear, prefetch_valid;
  logic exec_prefetched, vector_valid, asleep, timeout_flag, powerdown_flag, irq;
  logic [12:0] program_counter, pc_s, prefetch_addr, vector_addr;
  int error_cnt = 0, compares = 0, waited;
  always #50 clk = ~clk;
  always @(posedge clk) if (vector_valid === 1'b1) vseen <= 1'b1;
  swc_sleep_ctrl #(.OST_CYCLES(OST)) dut_u (.clk, .reset_n, .addr, .wdata, .wr_en, .rd_en,
    .rdata, .sleep_instr, .watchdog_clear_instruction, .branch_or_skip, .program_counter,
    .master_clear_pin_n, .watchdog_timeout(fl[4]), .ext_int_flag(fl[0]),
    .port_b_change_flag(fl[1]), .periph_flag(fl[2]), .timer_one_flag(fl[3]), .instr_cycle_en,
    .nop_cycle, .device_reset, .osc_driver_on, .watchdog_clear, .prefetch_valid, .prefetch_addr,
    .exec_prefetched, .vector_valid, .vector_addr, .asleep, .timeout_flag, .powerdown_flag, .irq);
  swc_seq_model seq_u (.clk, .rst_n(reset_n), .step(instr_cycle_en), .flush(nop_cycle), .op,
    .op_v, .sleep_instr, .watchdog_clear_instruction, .branch_or_skip, .program_counter, .busy);
  task automatic tally_and_finish();
    if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) {addr, wdata, wr_en} <= {a, d, 1'b1};
    @(posedge clk) wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clk) {addr, rd_en} <= {a, 1'b1};
    @(posedge clk) rd_en <= 1'b0;
    @(negedge clk) chk(n, rdata, e);
  endtask : rd
  function automatic logic hit(input int k);
    case (k)
      0: return asleep === 1'b1;
      1: return asleep === 1'b0;
      2: return exec_prefetched === 1'b1;
      3: return device_reset === 1'b1;
      default: return busy === 1'b0;
    endcase
  endfunction : hit
  // bounded wait, sampled at negedge
  task automatic hold(input int k, input int lim);
    @(negedge clk);
    for (waited = 0; !hit(k); waited++) begin
      if (waited >= lim) begin
        error_cnt++;
        tally_and_finish();
      end
      @(negedge clk);
    end
  endtask : hold
  task automatic cmd(input logic [1:0] o);
    @(posedge clk) {op, op_v} <= {o, 1'b1};
    @(posedge clk) op_v <= 1'b0;
    hold(4, 40);
  endtask : cmd
  // watchdog clear, then sleep; expect entry or a nop
  task automatic nap(input logic ent);
    cmd(2'h2);
    pc_s = program_counter;
    cmd(2'h1);
    if (ent) hold(0, 20);
    else repeat (10) @(negedge clk);
  endtask : nap
  // raise wake levels, await the prefetched run, drop them
  task automatic wake(input logic [4:0] m, input int lim);
    @(posedge clk) fl <= m;
    hold(1, 20);
    hold(2, lim);
    @(posedge clk) fl <= 5'h00;
  endtask : wake
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (OST + 20) @(posedge clk);
    rd(`SWC_ADDR_STATUS, 32'h13, "status");
    rd(8'h1C, 32'h0, "unmapped");
    rd(`SWC_ADDR_IRQ_CLR, 32'h0, "irq_clr");
    wr(`SWC_ADDR_CTRL, 32'h3);
    wr(`SWC_ADDR_SRC_EN, 32'h7);
    wr(`SWC_ADDR_IRQ_EN, 32'h1F);
    cmd(2'h3);
    nap(1'b1);
    chk("prefetch", prefetch_addr, pc_s + 13'h1);
    chk("pd_sleep", {timeout_flag, powerdown_flag}, 2'b10);
    chk("irq_set", irq, 1'b1);
    wr(`SWC_ADDR_IRQ_CLR, 32'h1F);
    @(negedge clk) chk("irq_clr", irq, 1'b0);
    wake(5'h01, 20);
    repeat (10) @(negedge clk);
    chk("no_vector", vseen, 1'b0);
    chk("pd_int", {timeout_flag, powerdown_flag}, 2'b10);
    rd(`SWC_ADDR_IRQ_STAT, 32'h08, "irq_stat");
    wr(`SWC_ADDR_CTRL, 32'h7);
    nap(1'b1);
    wake(5'h02, 20);
    repeat (10) @(negedge clk);
    chk("vector", vseen, 1'b1);
    wr(`SWC_ADDR_SRC_EN, 32'h6);
    nap(1'b1);
    @(posedge clk) fl <= 5'h09;
    wr(`SWC_ADDR_SRC_EN, 32'hE);
    repeat (20) @(negedge clk);
    chk("masked", asleep, 1'b1);
    wr(`SWC_ADDR_CTRL, 32'hF);
    wake(5'h09, 20);
    wr(`SWC_ADDR_CTRL, 32'h3);
    wr(`SWC_ADDR_SRC_EN, 32'hF);
    @(posedge clk) fl <= 5'h04;
    repeat (5) @(posedge clk);
    nap(1'b0);
    chk("nop_sleep", {asleep, powerdown_flag}, 2'b01);
    @(posedge clk) fl <= 5'h00;
    repeat (5) @(posedge clk);
    nap(1'b1);
    @(posedge clk) fl <= 5'h10;
    hold(1, 20);
    repeat (3) @(negedge clk);
    chk("wdt_to", timeout_flag, 1'b0);
    @(posedge clk) fl <= 5'h00;
    wr(`SWC_ADDR_CTRL, 32'h1);
    nap(1'b1);
    wake(5'h01, OST + 30);
    chk("ost", waited >= OST, 1'b1);
    nap(1'b1);
    @(posedge clk) master_clear_pin_n <= 1'b0;
    hold(3, 10);
    repeat (8) @(posedge clk);
    master_clear_pin_n <= 1'b1;
    repeat (OST + 20) @(posedge clk);
    tally_and_finish();
  end
endmodule : tb_swc_sleep_ctrl
`default_nettype wire
